// ===== core/epc_parport.sv
// Purpose: Parallel host port with EPP read/write cycles and ECP registers
// Assumes: Host I/O cycles arrive decoded, one at a time, on SYS_CLK_I
// Notes:   Peripheral pins are synchronised; the ECP link engine is
//          outside and trades words over the FWD/REV streams
//
// Functional notes
// - A host EPP read asserts the data or address strobe.
// - Host read is held in wait states while the wait line is low.
// - Read ends with the final answer and the strobe released.
// - After a cycle the write line and bus drive may change.
// - Write line is low for writes, high otherwise.
// - Peripheral interrupt passes through active high, not inverted.
// - Separate active-low strobes mark data and address cycles.
// - Active-low init output resets the peripheral.
// - The control port may override both the write line and the bus drive.
// - Standard and EPP modes share one data register.
// - The ECP port word is eight bits wide.
// - Forward runs host to peripheral, reverse the other way.
// - Status and control registers are reachable in every mode.
// - All mode FIFOs share one sixteen-byte FIFO.
// - Config B reads back the selected interrupt and DMA channel.
// - EPP cycle over ten microseconds aborts and sets status bit 0.
`timescale 1ns/1ns
`default_nettype none
module epc_parport #(
  parameter int TIMEOUT_CYC = epc_pkg::TO_CYC,
  parameter int FIFO_DEPTH  = epc_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RST_N_I,
  // Host I/O cycle
  input  wire logic                  IO_REQ_I,
  input  wire epc_pkg::epc_io_req_t  IO_CMD_I,
  output logic                       IO_DONE_O,
  output logic [7:0]                 IO_RDATA_O,
  // Configuration selections
  input  wire logic [2:0]            CFG_IRQ_SEL_I,
  input  wire logic [2:0]            CFG_DMA_SEL_I,
  // Parallel data bus
  input  wire logic [7:0]            PORT_DATA_BUS_I,
  output logic [7:0]                 PORT_DATA_BUS_O,
  output logic                       PORT_DATA_BUS_OE_O,
  // EPP and control pins
  output logic                       WRITE_LINE_N_O,
  output logic                       DATA_PHASE_STROBE_N_O,
  output logic                       ADDR_PHASE_STROBE_N_O,
  output logic [3:0]                 CTL_PINS_N_O,
  input  wire logic                  PERIPHERAL_WAIT_N_I,
  input  wire logic                  PERIPHERAL_INTERRUPT_I,
  input  wire epc_pkg::epc_sts_pins_t STS_PINS_I,
  output logic                       PERIPH_IRQ_O,
  // ECP link engine streams
  output logic                       FWD_VALID_O,
  output epc_pkg::epc_word_t         FWD_WORD_O,
  input  wire logic                  FWD_READY_I,
  input  wire logic                  REV_VALID_I,
  input  wire logic [7:0]            REV_DATA_I,
  output logic                       REV_READY_O
);
  import epc_pkg::*;

  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  typedef struct packed {
    epc_fsm_t       fsm;
    logic           epp_rd;
    logic           epp_addr;
    logic [7:0]     data;
    logic [5:0]     ctl;
    logic [5:0]     ecr;
    logic           tmo;
    logic [CW-1:0]  cnt;
    logic [1:0][7:0] pd_s;
    logic [1:0]     wait_s;
    logic [1:0]     peripheral_interrupt_s;
    logic [1:0][4:0] sts_s;
    logic           done;
    logic [7:0]     rdata;
    logic           irq;
    logic           wr_n;
    logic           ds_n;
    logic           as_n;
    logic           oe;
    logic [3:0]     pins_n;
    logic           rev_rdy;
  } epc_top_st_t;

  localparam epc_top_st_t ST_RST = '{
    fsm: EPC_IDLE, wr_n: 1'b1, ds_n: 1'b1, as_n: 1'b1,
    ctl: CTL_RST, ecr: ECR_RST, pins_n: OUT_PINS_RST, default: '0};

  epc_top_st_t   st;
  epc_top_st_t   nx;
  epc_mode_t     mode;
  epc_sts_pins_t sts;
  logic          req;
  logic          fifo_fwd;
  logic          host_push;
  logic          host_pop;
  logic          rev_push;
  logic          f_clr;
  logic          f_in_r;
  logic          f_out_v;
  logic          f_out_r;
  logic          b_in_r;
  epc_word_t     f_in_d;
  epc_word_t     f_out_d;
  logic [LW-1:0] f_lvl;

  always_comb begin
    nx        = st;
    mode      = epc_mode_t'(st.ecr[5:ECR_MODE_LSB]);
    sts       = epc_sts_pins_t'(st.sts_s[1]);
    req       = IO_REQ_I && (st.fsm == EPC_IDLE);
    host_push = 1'b0;
    host_pop  = 1'b0;
    f_clr     = 1'b0;
    f_in_d    = '{cmd: 1'b0, data: IO_CMD_I.wdata};
    // Forward modes drain the FIFO towards the link engine
    fifo_fwd  = (mode == EPC_MODE_FIFO) ||
                (mode == EPC_MODE_ECP && !st.ctl[CTL_DIR]);
    rev_push  = REV_VALID_I && st.rev_rdy &&
                mode == EPC_MODE_ECP && st.ctl[CTL_DIR];

    // Pin synchronisers; stage 0 feeds stage 1 only
    nx.pd_s   = {st.pd_s[0], PORT_DATA_BUS_I};
    nx.wait_s = {st.wait_s[0], PERIPHERAL_WAIT_N_I};
    nx.peripheral_interrupt_s = {st.peripheral_interrupt_s[0], PERIPHERAL_INTERRUPT_I};
    nx.sts_s  = {st.sts_s[0], STS_PINS_I};
    nx.irq    = st.peripheral_interrupt_s[1];
    nx.done   = 1'b0;

    case (st.fsm)
      EPC_IDLE: begin
        nx.wr_n = 1'b1;
        if (req) begin
          nx.done  = 1'b1;
          nx.rdata = UNMAPPED_VAL;
          case (IO_CMD_I.addr)
            OFS_DATA: begin
              if (mode == EPC_MODE_ECP && IO_CMD_I.wr) begin
                // Entry's command flag is set; tag bit 7 rides along in the data byte
                f_in_d    = '{cmd: 1'b1, data: IO_CMD_I.wdata};
                host_push = 1'b1;
              end else if (IO_CMD_I.wr) begin
                nx.data = IO_CMD_I.wdata;
              end else begin
                nx.rdata = st.pd_s[1];
              end
            end
            OFS_STATUS: begin
              nx.rdata = {~sts.busy, sts.ack_n, sts.perror, sts.select,
                          sts.fault_n, 2'b00,
                          st.tmo && mode == EPC_MODE_EPP};
              if (!IO_CMD_I.wr) begin
                nx.tmo = 1'b0;
              end
            end
            OFS_CONTROL: begin
              nx.rdata = {2'b00, st.ctl};
              if (IO_CMD_I.wr) begin
                nx.ctl = IO_CMD_I.wdata[5:0];
              end
            end
            OFS_EPP_ADDR, OFS_EPP_DATA: begin
              if (mode == EPC_MODE_EPP) begin
                nx.done     = 1'b0;
                nx.fsm      = EPC_STB;
                nx.epp_rd   = !IO_CMD_I.wr;
                nx.epp_addr = (IO_CMD_I.addr == OFS_EPP_ADDR);
                nx.cnt      = '0;
                if (IO_CMD_I.wr) begin
                  nx.data = IO_CMD_I.wdata;
                end
              end
            end
            OFS_FIFO: begin
              if (mode == EPC_MODE_CFG && !IO_CMD_I.wr) begin
                nx.rdata = CFG_A_VAL;
              end else if (IO_CMD_I.wr && (fifo_fwd ||
                           mode == EPC_MODE_TEST)) begin
                host_push = 1'b1;
              end else if (!IO_CMD_I.wr && (mode == EPC_MODE_TEST ||
                           (mode == EPC_MODE_ECP && st.ctl[CTL_DIR]))) begin
                host_pop = f_out_v;
                nx.rdata = f_out_v ? f_out_d.data : UNMAPPED_VAL;
              end
            end
            OFS_CFG_B: begin
              nx.rdata = {1'b0, st.irq, CFG_IRQ_SEL_I, CFG_DMA_SEL_I};
            end
            OFS_EXT_CTL: begin
              nx.rdata = {st.ecr, ~f_in_r, ~f_out_v};
              if (IO_CMD_I.wr) begin
                nx.ecr = IO_CMD_I.wdata[7:2];
                // Selecting SPP or PS2 mode discards stale bytes
                f_clr  = (IO_CMD_I.wdata[7:5] == EPC_MODE_SPP) ||
                         (IO_CMD_I.wdata[7:5] == EPC_MODE_PS2);
              end
            end
            default: begin
              nx.rdata = UNMAPPED_VAL;
            end
          endcase
        end
      end
      EPC_STB: begin
        // Write line settles one cycle and the bus two cycles before the strobe
        nx.wr_n = st.epp_rd && !st.ctl[CTL_STROBE];
        nx.fsm  = EPC_HOLD;
      end
      EPC_HOLD: begin
        nx.ds_n = st.epp_addr;
        nx.as_n = !st.epp_addr;
        nx.cnt  = CW'(st.cnt + 1'b1);
        if (st.wait_s[1]) begin
          // Data was valid before wait rose; sampled with same delay
          nx.fsm   = EPC_END;
          nx.done  = 1'b1;
          nx.rdata = st.epp_rd ? st.pd_s[1] : UNMAPPED_VAL;
          nx.ds_n  = 1'b1;
          nx.as_n  = 1'b1;
        end else if (st.cnt == CW'(TIMEOUT_CYC)) begin
          nx.fsm   = EPC_END;
          nx.done  = 1'b1;
          nx.tmo   = 1'b1;
          nx.rdata = UNMAPPED_VAL;
          nx.ds_n  = 1'b1;
          nx.as_n  = 1'b1;
        end
      end
      EPC_END: begin
        nx.wr_n = 1'b1;
        nx.fsm  = EPC_IDLE;
      end
      default: begin
        nx = ST_RST;
      end
    endcase

    // Bus released during EPP reads unless strobe forces write mode
    if (nx.fsm == EPC_IDLE) begin
      nx.oe = !nx.ctl[CTL_DIR];
    end else begin
      // Next-cycle direction, so the bus is released from the STB cycle
      nx.oe = !nx.epp_rd || nx.ctl[CTL_STROBE];
    end
    nx.pins_n = {~nx.ctl[CTL_SELIN], nx.ctl[CTL_INIT],
                 ~nx.ctl[CTL_AUTOFD], ~nx.ctl[CTL_STROBE]};
    // One free slot of margin covers a push made this cycle
    nx.rev_rdy = mode == EPC_MODE_ECP && st.ctl[CTL_DIR] &&
                 (f_lvl <= LW'(FIFO_DEPTH - 2));
    if (rev_push) begin
      f_in_d = '{cmd: 1'b0, data: REV_DATA_I};
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  assign f_out_r = fifo_fwd ? b_in_r : host_pop;

  // Single shared byte FIFO for all ECP-side modes
  epc_fifo #(
    .W     (DATA_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (SYS_CLK_I),
    .rst_n_i     (RST_N_I),
    .clear_i     (f_clr),
    .in_valid_i  (host_push || rev_push),
    .in_ready_o  (f_in_r),
    .in_data_i   (f_in_d),
    .out_valid_o (f_out_v),
    .out_ready_i (f_out_r),
    .out_data_o  (f_out_d),
    .level_o     (f_lvl)
  );

  // Two-entry buffer so a link-side stall loses no word
  epc_fifo #(
    .W     (DATA_W + 1),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i       (SYS_CLK_I),
    .rst_n_i     (RST_N_I),
    .clear_i     (f_clr),
    .in_valid_i  (f_out_v && fifo_fwd),
    .in_ready_o  (b_in_r),
    .in_data_i   (f_out_d),
    .out_valid_o (FWD_VALID_O),
    .out_ready_i (FWD_READY_I),
    .out_data_o  (FWD_WORD_O),
    .level_o     ()
  );

  assign IO_DONE_O             = st.done;
  assign IO_RDATA_O            = st.rdata;
  assign PORT_DATA_BUS_O       = st.data;
  assign PORT_DATA_BUS_OE_O    = st.oe;
  assign WRITE_LINE_N_O        = st.wr_n;
  assign DATA_PHASE_STROBE_N_O = st.ds_n;
  assign ADDR_PHASE_STROBE_N_O = st.as_n;
  assign CTL_PINS_N_O          = st.pins_n;
  assign PERIPH_IRQ_O          = st.irq;
  assign REV_READY_O           = st.rev_rdy;

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  chk_strobe_excl:
    assert property (!(!st.ds_n && !st.as_n))
      else $error("both EPP strobes low");
  chk_read_release:
    assert property ((st.fsm == EPC_HOLD && st.epp_rd &&
                      !st.ctl[CTL_STROBE]) |-> (!st.oe && st.wr_n))
      else $error("bus or write line wrong during EPP read");
  chk_write_low:
    assert property ((st.fsm == EPC_HOLD && !st.epp_rd) |-> !st.wr_n)
      else $error("write line high during EPP write");
  chk_wait_stretch:
    assert property ((st.fsm == EPC_HOLD && !st.wait_s[1] &&
                      st.cnt != CW'(TIMEOUT_CYC)) |=> !st.done)
      else $error("host answered while wait held");
  chk_end_release:
    assert property ((st.fsm == EPC_HOLD && st.wait_s[1]) |=>
                     (st.done && st.ds_n && st.as_n) ##1 st.fsm == EPC_IDLE)
      else $error("EPP cycle did not end cleanly");
  chk_timeout_set:
    assert property ((st.fsm == EPC_HOLD && !st.wait_s[1] &&
                      st.cnt == CW'(TIMEOUT_CYC)) |=> (st.tmo && st.done))
      else $error("watchdog did not abort");
  chk_irq_pass:
    assert property (PERIPHERAL_INTERRUPT_I |-> ##3 st.irq)
      else $error("interrupt not passed through");
  chk_cfga_value:
    assert property ((req && !IO_CMD_I.wr && IO_CMD_I.addr == OFS_FIFO &&
                      mode == EPC_MODE_CFG) |=> (st.done &&
                      st.rdata == CFG_A_VAL))
      else $error("config A value wrong");
  chk_fifo_full:
    assert property ((f_lvl == LW'(FIFO_DEPTH)) |-> !f_in_r)
      else $error("FIFO accepts beyond depth");
  chk_init_follow:
    assert property ($changed(st.ctl) |-> st.pins_n[PIN_INIT] ==
                     st.ctl[CTL_INIT])
      else $error("init pin does not follow control");

endmodule
`default_nettype wire

// ===== core/epc_pkg.sv
// Purpose: Shared constants and types for the parallel host port block
// Assumes: 125 MHz system clock, 8-bit host I/O data path
// Notes:   Offsets are register indices on the host I/O decode
package epc_pkg;

  // Port word width, fixed to the host data path
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Register offsets
  localparam logic [3:0] OFS_DATA      = 4'h0;
  localparam logic [3:0] OFS_STATUS    = 4'h1;
  localparam logic [3:0] OFS_CONTROL   = 4'h2;
  localparam logic [3:0] OFS_EPP_ADDR  = 4'h3;
  localparam logic [3:0] OFS_EPP_DATA  = 4'h4;
  localparam logic [3:0] OFS_FIFO      = 4'h8;
  localparam logic [3:0] OFS_CFG_B     = 4'h9;
  localparam logic [3:0] OFS_EXT_CTL   = 4'hA;

  // Control register fields
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELIN  = 3;
  localparam int CTL_ACKINT = 4;
  localparam int CTL_DIR    = 5;

  // Extended control fields (upper six bits stored)
  localparam int ECR_MODE_LSB = 3;
  localparam int ECR_FULL     = 1;
  localparam int ECR_EMPTY    = 0;

  // Output pin vector order {select_in_n, init_n, autofd_n, strobe_n}
  localparam int PIN_INIT = 2;

  // Reset values
  localparam logic [5:0] CTL_RST      = 6'h00;
  localparam logic [5:0] ECR_RST      = 6'h00;
  localparam logic [3:0] OUT_PINS_RST = 4'hB;
  localparam logic [7:0] CFG_A_VAL    = 8'h10;
  localparam logic [7:0] UNMAPPED_VAL = 8'hFF;

  // Address/RLE entry: bit 7 tags address versus run count
  localparam int AFIFO_TAG_BIT = 7;

  // Shared FIFO and output buffer depths
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int BUF_DEPTH      = 2;

  // EPP cycle watchdog
  localparam int CLK_MHZ = 125;
  localparam int TO_US   = 10;
  localparam int TO_CYC  = TO_US * CLK_MHZ;

  typedef enum logic [2:0] {
    EPC_MODE_SPP  = 3'h0,
    EPC_MODE_PS2  = 3'h1,
    EPC_MODE_FIFO = 3'h2,
    EPC_MODE_ECP  = 3'h3,
    EPC_MODE_EPP  = 3'h4,
    EPC_MODE_RSVD = 3'h5,
    EPC_MODE_TEST = 3'h6,
    EPC_MODE_CFG  = 3'h7
  } epc_mode_t;

  typedef enum logic [3:0] {
    EPC_IDLE = 4'h1,
    EPC_STB  = 4'h2,
    EPC_HOLD = 4'h4,
    EPC_END  = 4'h8
  } epc_fsm_t;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } epc_io_req_t;

  typedef struct packed {
    logic busy;
    logic ack_n;
    logic perror;
    logic select;
    logic fault_n;
  } epc_sts_pins_t;

  // cmd is set for entries from the address/RLE register
  typedef struct packed {
    logic              cmd;
    logic [DATA_W-1:0] data;
  } epc_word_t;

endpackage

// ===== core/epc_fifo.sv
// Purpose: Shift-style FIFO with valid/ready on both sides
// Assumes: At most one push and one pop per cycle
// Notes:   Head entry is a flip-flop so outputs need no read mux
`timescale 1ns/1ns
`default_nettype none
module epc_fifo #(
  parameter  int W     = 9,
  parameter  int DEPTH = 16,
  localparam int LW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          clear_i,
  // Fill side
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  input  wire logic [W-1:0]  in_data_i,
  // Drain side
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  output logic [W-1:0]       out_data_o,
  // Fill level
  output logic [LW-1:0]      level_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [DEPTH-1:0]        vld;
    logic [LW-1:0]           cnt;
  } epc_fifo_st_t;

  epc_fifo_st_t   st;
  epc_fifo_st_t   nx;
  logic           push;
  logic           pop;
  logic [PW-1:0]  wr_idx;

  assign in_ready_o  = ~st.vld[DEPTH-1];
  assign out_valid_o = st.vld[0];
  assign out_data_o  = st.mem[0];
  assign level_o     = st.cnt;

  always_comb begin
    push   = in_valid_i & ~st.vld[DEPTH-1];
    pop    = out_ready_i & st.vld[0];
    wr_idx = pop ? PW'(st.cnt - 1'b1) : PW'(st.cnt);
    nx     = st;
    if (clear_i) begin
      nx.vld = '0;
      nx.cnt = '0;
    end else begin
      if (pop) begin
        nx.mem = st.mem >> W;
        nx.vld = st.vld >> 1;
      end
      if (push) begin
        nx.mem[wr_idx] = in_data_i;
        nx.vld[wr_idx] = 1'b1;
      end
      nx.cnt = LW'(st.cnt + LW'(push) - LW'(pop));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

endmodule
`default_nettype wire

// ===== tb/epc_periph_model.sv
// Purpose: Behavioural EPP peripheral on the far side of the parallel port
// Assumes: Strobes and write line come straight from the port's pins
// Notes:   Between strobes a released bus shows the inverse of the last byte each cycle,
//          so a sample of a floating bus cannot pass by luck
`timescale 1ns/1ns
`default_nettype none
module epc_periph_model (
  // Clock
  input  wire logic       clk_i,
  // Port side
  input  wire logic       data_stb_n_i,
  input  wire logic       addr_stb_n_i,
  input  wire logic       write_line_n_i,
  // Behaviour control
  input  wire logic [3:0] delay_i,
  input  wire logic       stuck_i,
  input  wire logic [7:0] rd_byte_i,
  // Pins driven by the peripheral
  output logic            wait_n_o,
  output logic [7:0]      data_o,
  output logic            drive_o
);
  logic [4:0] cnt;

  initial begin
    cnt      = 5'h00;
    wait_n_o = 1'b0;
    data_o   = 8'h00;
    drive_o  = 1'b0;
  end

  always @(posedge clk_i) begin
    if (data_stb_n_i && addr_stb_n_i) begin
      cnt      <= 5'h00;
      wait_n_o <= 1'b0;
      drive_o  <= 1'b0;
      data_o   <= ~data_o;
    end else begin
      cnt <= cnt + 5'h01;
      if (!write_line_n_i && cnt >= {1'b0, delay_i}) begin
        wait_n_o <= !stuck_i;
      end
      if (write_line_n_i && cnt == {1'b0, delay_i}) begin
        drive_o <= 1'b1;
        data_o  <= rd_byte_i;
      end
      // Wait released only a cycle after the data is on the bus
      if (write_line_n_i && cnt > {1'b0, delay_i}) begin
        wait_n_o <= !stuck_i;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/epc_parport_tb.sv
// Purpose: Self-checking bench for the parallel host port
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Watchdog shortened to 20 cycles to keep timeout runs short
`timescale 1ns/1ns
`default_nettype none
module epc_parport_tb;
  import epc_pkg::*;
  localparam int TO = 20;
  logic SYS_CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic IO_REQ_I = 1'b0;
  epc_io_req_t IO_CMD_I = '0;
  logic IO_DONE_O, PORT_DATA_BUS_OE_O, WRITE_LINE_N_O, PERIPH_IRQ_O;
  logic DATA_PHASE_STROBE_N_O, ADDR_PHASE_STROBE_N_O;
  logic FWD_VALID_O, REV_READY_O, mwait_n, mdrive;
  logic [7:0] IO_RDATA_O, PORT_DATA_BUS_O, mdata, q;
  logic [3:0] CTL_PINS_N_O, mdelay = 4'h3;
  logic [2:0] irq_sel = 3'h0, dma_sel = 3'h0;
  logic mstuck = 1'b0, irq_in = 1'b0, fwd_rdy = 1'b0, rev_vld = 1'b0;
  logic [7:0] rev_dat = 8'h00;
  epc_sts_pins_t sts = 5'b0_1_0_1_1;
  epc_word_t FWD_WORD_O;
  epc_word_t fwd_q[$];
  int mismatches = 0, checks = 0, nd, na, nbad, cyc, n;
  logic exp_wl, exp_oe;
  logic [7:0] exp_bus;

  always #4 SYS_CLK_I = ~SYS_CLK_I;

  epc_parport #(.TIMEOUT_CYC(TO), .FIFO_DEPTH(FIFO_DEPTH_DEF)) epc_parport_i (
    .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .IO_REQ_I(IO_REQ_I),
    .IO_CMD_I(IO_CMD_I), .IO_DONE_O(IO_DONE_O), .IO_RDATA_O(IO_RDATA_O),
    .CFG_IRQ_SEL_I(irq_sel), .CFG_DMA_SEL_I(dma_sel),
    .PORT_DATA_BUS_I(PORT_DATA_BUS_OE_O ? PORT_DATA_BUS_O : mdata),
    .PORT_DATA_BUS_O(PORT_DATA_BUS_O), .PORT_DATA_BUS_OE_O(PORT_DATA_BUS_OE_O),
    .WRITE_LINE_N_O(WRITE_LINE_N_O),
    .DATA_PHASE_STROBE_N_O(DATA_PHASE_STROBE_N_O),
    .ADDR_PHASE_STROBE_N_O(ADDR_PHASE_STROBE_N_O),
    .CTL_PINS_N_O(CTL_PINS_N_O), .PERIPHERAL_WAIT_N_I(mwait_n),
    .PERIPHERAL_INTERRUPT_I(irq_in), .STS_PINS_I(sts),
    .PERIPH_IRQ_O(PERIPH_IRQ_O), .FWD_VALID_O(FWD_VALID_O),
    .FWD_WORD_O(FWD_WORD_O), .FWD_READY_I(fwd_rdy), .REV_VALID_I(rev_vld),
    .REV_DATA_I(rev_dat), .REV_READY_O(REV_READY_O));

  epc_periph_model epc_periph_model_i (
    .clk_i(SYS_CLK_I), .data_stb_n_i(DATA_PHASE_STROBE_N_O),
    .addr_stb_n_i(ADDR_PHASE_STROBE_N_O), .write_line_n_i(WRITE_LINE_N_O),
    .delay_i(mdelay), .stuck_i(mstuck), .rd_byte_i(8'h3C),
    .wait_n_o(mwait_n), .data_o(mdata), .drive_o(mdrive));

  // Pin levels seen while a strobe is low
  always @(posedge SYS_CLK_I) begin
    if (FWD_VALID_O === 1'b1 && fwd_rdy) fwd_q.push_back(FWD_WORD_O);
    if (!DATA_PHASE_STROBE_N_O || !ADDR_PHASE_STROBE_N_O) begin
      nd += !DATA_PHASE_STROBE_N_O;
      na += !ADDR_PHASE_STROBE_N_O;
      if (WRITE_LINE_N_O !== exp_wl || PORT_DATA_BUS_OE_O !== exp_oe ||
          (!exp_wl && PORT_DATA_BUS_O !== exp_bus)) nbad++;
      if (mdrive === 1'b1 && PORT_DATA_BUS_OE_O === 1'b1) nbad++;
    end
  end

  task automatic check(input string nm, input logic [8:0] s, input logic [8:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic io(input logic w, input logic [3:0] a, input logic [7:0] d);
    IO_CMD_I.wr = w;
    IO_CMD_I.addr = a;
    IO_CMD_I.wdata = d;
    IO_REQ_I = 1'b1;
    @(posedge SYS_CLK_I);
    #1 IO_REQ_I = 1'b0;
    cyc = 0;
    while (IO_DONE_O !== 1'b1 && cyc < 2000) begin
      @(posedge SYS_CLK_I);
      #1 cyc++;
    end
    if (cyc >= 2000) check("io_done", 9'h0, 9'h1);
    q = IO_RDATA_O;
    // An EPP cycle needs one more edge before the port is idle again
    @(posedge SYS_CLK_I);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    io(1'b0, a, 8'h00);
    check($sformatf("rd_%h", a), q, e);
  endtask

  // EPP cycle with expected strobe usage and pin levels
  task automatic epp(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic xd, input logic xa);
    nd = 0;
    na = 0;
    nbad = 0;
    exp_wl = !w;
    exp_oe = w;
    exp_bus = d;
    io(w, a, d);
    if (!w) check("epp_rdata", q, e);
    check("data_stb_used", nd != 0, xd);
    check("addr_stb_used", na != 0, xa);
    check("pins_in_cycle", nbad, 0);
    check("stb_released", {DATA_PHASE_STROBE_N_O, ADDR_PHASE_STROBE_N_O},
          9'h3);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge SYS_CLK_I);
    #1 RST_N_I = 1'b1;
    check("ctl_pins_rst", CTL_PINS_N_O, OUT_PINS_RST);
    check("wl_rst", WRITE_LINE_N_O, 1'b1);
    rd(OFS_CONTROL, 8'h00);
    rd(OFS_EXT_CTL, 8'h01);
    rd(OFS_STATUS, 8'hD8);
    rd(4'h5, UNMAPPED_VAL);
    rd(OFS_EPP_DATA, UNMAPPED_VAL);
    io(1'b1, OFS_EXT_CTL, 8'hE0);
    rd(OFS_FIFO, CFG_A_VAL);
    for (int i = 0; i < 8; i++) begin
      irq_sel = i[2:0];
      dma_sel = 3'h7 - i[2:0];
      io(1'b0, OFS_CFG_B, 8'h00);
      check("cfg_b", q & 8'h3F, {2'b00, i[2:0], 3'h7 - i[2:0]});
    end
    io(1'b1, OFS_CONTROL, 8'h04);
    check("init_released", CTL_PINS_N_O, 4'hF);
    io(1'b1, OFS_DATA, 8'h5A);
    check("spp_bus", {PORT_DATA_BUS_OE_O, PORT_DATA_BUS_O}, 9'h15A);
    // EPP mode, control and status stay reachable
    io(1'b1, OFS_EXT_CTL, 8'h80);
    rd(OFS_STATUS, 8'hD8);
    io(1'b1, OFS_CONTROL, 8'h24);
    rd(OFS_CONTROL, 8'h24);
    epp(1'b0, OFS_EPP_DATA, 8'h00, 8'h3C, 1'b1, 1'b0);
    epp(1'b0, OFS_EPP_ADDR, 8'h00, 8'h3C, 1'b0, 1'b1);
    mdelay = 4'hC;
    epp(1'b0, OFS_EPP_DATA, 8'h00, 8'h3C, 1'b1, 1'b0);
    check("wait_stretch", cyc >= 12, 1'b1);
    io(1'b1, OFS_CONTROL, 8'h04);
    epp(1'b1, OFS_EPP_DATA, 8'hC3, 8'h00, 1'b1, 1'b0);
    epp(1'b1, OFS_EPP_ADDR, 8'h96, 8'h00, 1'b0, 1'b1);
    check("shared_data", PORT_DATA_BUS_O, 8'h96);
    // Strobe bit forces a write during an EPP read
    io(1'b1, OFS_CONTROL, 8'h25);
    nd = 0;
    nbad = 0;
    exp_wl = 1'b0;
    exp_oe = 1'b1;
    exp_bus = 8'h96;
    io(1'b0, OFS_EPP_DATA, 8'h00);
    check("stb_override_used", nd != 0, 1'b1);
    check("stb_override", nbad, 0);
    mstuck = 1'b1;
    io(1'b1, OFS_CONTROL, 8'h24);
    epp(1'b0, OFS_EPP_DATA, 8'h00, 8'hFF, 1'b1, 1'b0);
    check("timeout_len", cyc >= TO && cyc <= TO + 8, 1'b1);
    rd(OFS_STATUS, 8'hD9);
    rd(OFS_STATUS, 8'hD8);
    mstuck = 1'b0;
    mdelay = 4'h2;
    // Compat FIFO fill with the link engine stalled
    io(1'b1, OFS_EXT_CTL, 8'h40);
    io(1'b1, OFS_CONTROL, 8'h04);
    rd(OFS_EXT_CTL, 8'h41);
    n = 0;
    q = 8'h00;
    while (!q[ECR_FULL] && n < 24) begin
      io(1'b1, OFS_FIFO, 8'hA0 + n[7:0]);
      n++;
      io(1'b0, OFS_EXT_CTL, 8'h00);
    end
    check("fifo_cap", n >= FIFO_DEPTH_DEF && n <= 24, 1'b1);
    io(1'b1, OFS_FIFO, 8'h77);
    fwd_rdy = 1'b1;
    repeat (n + 6) @(posedge SYS_CLK_I);
    #1 check("fwd_count", fwd_q.size(), n);
    for (int i = 0; i < n; i++) begin
      check("fwd_word", fwd_q.pop_front(), {1'b0, 8'hA0 + i[7:0]});
    end
    rd(OFS_EXT_CTL, 8'h41);
    // ECP forward with an address/RLE entry
    io(1'b1, OFS_EXT_CTL, 8'h60);
    io(1'b1, OFS_DATA, 8'h85);
    io(1'b1, OFS_FIFO, 8'h11);
    repeat (6) @(posedge SYS_CLK_I);
    #1 check("afifo_word", fwd_q.pop_front(), 9'h185);
    check("dfifo_word", fwd_q.pop_front(), 9'h011);
    // ECP reverse into the shared FIFO
    io(1'b1, OFS_CONTROL, 8'h24);
    rd(OFS_CONTROL, 8'h24);
    rev_vld = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rev_dat = 8'h51 + i[7:0];
      n = 0;
      while (REV_READY_O !== 1'b1 && n < 50) begin
        @(posedge SYS_CLK_I);
        #1 n++;
      end
      @(posedge SYS_CLK_I);
      #1;
    end
    rev_vld = 1'b0;
    repeat (4) @(posedge SYS_CLK_I);
    #1 for (int i = 0; i < 3; i++) rd(OFS_FIFO, 8'h51 + i[7:0]);
    rd(OFS_FIFO, 8'hFF);
    // Test mode loops a byte through the shared FIFO
    io(1'b1, OFS_EXT_CTL, 8'hC0);
    io(1'b1, OFS_FIFO, 8'h3A);
    rd(OFS_FIFO, 8'h3A);
    io(1'b1, OFS_FIFO, 8'h3B);
    io(1'b1, OFS_EXT_CTL, 8'h20);
    rd(OFS_EXT_CTL, 8'h21);
    irq_in = 1'b1;
    repeat (4) @(posedge SYS_CLK_I);
    #1 check("irq_high", PERIPH_IRQ_O, 1'b1);
    irq_in = 1'b0;
    repeat (4) @(posedge SYS_CLK_I);
    #1 check("irq_low", PERIPH_IRQ_O, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
